// *** include/lsbm_pkg.sv ***
// Shared constants, types and helpers of the load-store bus master
package lsbm_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned ADDR_W     = 32;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned LANES      = 4;
    localparam int unsigned LANE_W     = 8;
    localparam int unsigned MAX_OUTST  = 2;
    localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
    localparam logic [1:0]  OUTST_LIM  = 2'h2;

    // ****************************************
    // Access sizes and lane masks
    // ****************************************
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [3:0] MASK_BYTE = 4'h1;
    localparam logic [3:0] MASK_HALF = 4'h3;
    localparam logic [3:0] MASK_WORD = 4'hf;
    localparam logic [1:0] OFS_LAST  = 2'h3;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ISSUE0 = 2'b01,
        ST_ISSUE1 = 2'b10,
        ST_WAIT   = 2'b11
    } lsbm_state_e;

    // Lanes touched by an access of the given size
    function automatic logic [3:0] size_mask(input logic [1:0] size);
        unique case (size)
            SIZE_BYTE: size_mask = MASK_BYTE;
            SIZE_HALF: size_mask = MASK_HALF;
            default:   size_mask = MASK_WORD;
        endcase
    endfunction

    // Access needs two word transactions
    function automatic logic needs_split(input logic [1:0] size, input logic [1:0] ofs);
        needs_split = ((size == SIZE_WORD) && (ofs != 2'h0)) ||
                      ((size == SIZE_HALF) && (ofs == OFS_LAST));
    endfunction

endpackage

// *** core/lsbm_split.sv ***
// Lane placement of store data and byte lane masks for one or two words
module lsbm_split
    import lsbm_pkg::*;
(
    input  wire logic [1:0]  size,
    input  wire logic [1:0]  ofs,
    input  wire logic [31:0] wdata,
    output logic      [3:0]  mask_lo,
    output logic      [3:0]  mask_hi,
    output logic      [31:0] wdata_lo,
    output logic      [31:0] wdata_hi
);

    logic [7:0]  mask_wide;
    logic [63:0] data_wide;

    // ****************************************
    // Shift lanes by low address bits
    // ****************************************
    always_comb begin
        mask_wide = {4'h0, size_mask(size)} << ofs;
        data_wide = {32'h0000_0000, wdata} << {ofs, 3'b000};
        mask_lo   = mask_wide[3:0];
        mask_hi   = mask_wide[7:4];
        wdata_lo  = data_wide[31:0];
        wdata_hi  = data_wide[63:32];
    end

endmodule // lsbm_split

// *** core/lsbm_merge.sv ***
// Merges response words, aligns the loaded item and extends it
module lsbm_merge
    import lsbm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        in_valid,
    input  wire logic [31:0] word_lo,
    input  wire logic [31:0] word_hi,
    input  wire logic [1:0]  ofs,
    input  wire logic [1:0]  size,
    input  wire logic        sign_ext,
    output logic             out_valid,
    output logic      [31:0] out_data
);

    logic        out_valid_ff;
    logic [31:0] out_data_ff;
    logic [63:0] joined;
    logic [31:0] nxt_data;

    // ****************************************
    // Align and extend
    // ****************************************
    always_comb begin
        joined = {word_hi, word_lo} >> {ofs, 3'b000};
        unique case (size)
            SIZE_BYTE: nxt_data = {{24{sign_ext & joined[7]}}, joined[7:0]};
            SIZE_HALF: nxt_data = {{16{sign_ext & joined[15]}}, joined[15:0]};
            default:   nxt_data = joined[31:0];
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            out_valid_ff <= 1'b0;
            out_data_ff  <= 32'h0000_0000;
        end else begin
            out_valid_ff <= in_valid;
            if (in_valid) begin
                out_data_ff <= nxt_data;
            end
        end
    end

    assign out_valid = out_valid_ff;
    assign out_data  = out_data_ff;

endmodule // lsbm_merge

// *** core/lsbm_core.sv ***
// Load-store bus master: request sequencing, splitting and responses
//
// How it works
// - Loads and stores come in word, halfword and byte sizes.
// - At most two granted transactions wait for a response; no queue.
// - Request stays high until grant is seen high for one cycle.
// - Address, write select, lane mask, write data change only after grant.
// - Write select is high for stores, low for loads, with the request.
// - A four-bit lane mask marks the bytes read or written.
// - Grant may come early; request and grant together mean acceptance.
// - Optional user, identifier, ready and error signals are left out.
// - No misaligned-address exception is ever raised.
// - Misaligned words and word-crossing halfwords take two transactions.
// - Of a split pair, the lower address goes first.
// - Every other access takes a single transaction.
// - With extensions on, post-increment uses base address and writes back base+offset.
module lsbm_core
    import lsbm_pkg::*;
#(
    parameter bit vendor_extensions_enable = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_we,
    input  wire logic [1:0]  cmd_size,
    input  wire logic        cmd_sign_ext,
    input  wire logic        cmd_post_inc,
    input  wire logic [31:0] cmd_base,
    input  wire logic [31:0] cmd_offset,
    input  wire logic [31:0] cmd_wdata,
    output logic      [31:0] eff_addr,
    output logic             load_valid,
    output logic      [31:0] load_data,
    output logic             store_done,
    output logic             base_wb_valid,
    output logic      [31:0] base_wb_data,
    output logic             data_req,
    input  wire logic        data_gnt,
    output logic      [31:0] data_addr,
    output logic             data_we,
    output logic      [3:0]  byte_lane_mask,
    output logic      [31:0] data_wdata,
    input  wire logic        data_rvalid,
    input  wire logic [31:0] data_rdata
);

    // ****************************************
    // Declarations
    // ****************************************
    lsbm_state_e state_ff;
    lsbm_state_e nxt_state;
    logic        accept;
    logic        granted;
    logic        last_rsp;
    logic        post_inc_on;
    logic [31:0] nxt_eff;
    logic [1:0]  outst_ff;
    logic        rsp_idx_ff;
    logic        split_ff;
    logic        we_ff;
    logic [1:0]  size_ff;
    logic [1:0]  ofs_ff;
    logic        sign_ff;
    logic [31:0] req_addr_ff;
    logic [3:0]  req_mask_ff;
    logic [3:0]  mask_hi_ff;
    logic [31:0] req_wd_ff;
    logic [31:0] wd_hi_ff;
    logic [31:0] word_lo_ff;
    logic [31:0] eff_ff;
    logic        store_done_ff;
    logic        wb_valid_ff;
    logic [31:0] wb_data_ff;
    logic [3:0]  sp_mask_lo;
    logic [3:0]  sp_mask_hi;
    logic [31:0] sp_wd_lo;
    logic [31:0] sp_wd_hi;
    logic [31:0] merge_lo;

    // ****************************************
    // Command acceptance and address
    // ****************************************
    assign cmd_ready   = (state_ff == ST_IDLE);
    assign accept      = cmd_valid & cmd_ready;
    assign post_inc_on = vendor_extensions_enable & cmd_post_inc;
    assign nxt_eff     = post_inc_on ? cmd_base : cmd_base + cmd_offset;
    assign granted     = data_req & data_gnt;
    assign last_rsp    = (state_ff == ST_WAIT) & data_rvalid & (rsp_idx_ff == split_ff);

    lsbm_split u_split (
        .size     (cmd_size),
        .ofs      (nxt_eff[1:0]),
        .wdata    (cmd_wdata),
        .mask_lo  (sp_mask_lo),
        .mask_hi  (sp_mask_hi),
        .wdata_lo (sp_wd_lo),
        .wdata_hi (sp_wd_hi)
    );

    // Access attributes held for the whole access
    always_ff @(posedge clk) begin
        if (reset) begin
            split_ff   <= 1'b0;
            we_ff      <= 1'b0;
            size_ff    <= SIZE_WORD;
            ofs_ff     <= 2'h0;
            sign_ff    <= 1'b0;
            mask_hi_ff <= 4'h0;
            wd_hi_ff   <= 32'h0000_0000;
            eff_ff     <= 32'h0000_0000;
        end else if (accept) begin
            split_ff   <= needs_split(cmd_size, nxt_eff[1:0]);
            we_ff      <= cmd_we;
            size_ff    <= cmd_size;
            ofs_ff     <= nxt_eff[1:0];
            sign_ff    <= cmd_sign_ext;
            mask_hi_ff <= sp_mask_hi;
            wd_hi_ff   <= sp_wd_hi;
            eff_ff     <= nxt_eff;
        end
    end

    // Request phase registers: low word on take, high word after the first grant
    always_ff @(posedge clk) begin
        if (reset) begin
            req_addr_ff <= 32'h0000_0000;
            req_mask_ff <= 4'h0;
            req_wd_ff   <= 32'h0000_0000;
        end else if (accept) begin
            req_addr_ff <= {nxt_eff[31:2], 2'b00};
            req_mask_ff <= sp_mask_lo;
            req_wd_ff   <= sp_wd_lo;
        end else if (granted && (state_ff == ST_ISSUE0) && split_ff) begin
            req_addr_ff <= req_addr_ff + WORD_STEP;
            req_mask_ff <= mask_hi_ff;
            req_wd_ff   <= wd_hi_ff;
        end
    end

    // Base register write-back
    always_ff @(posedge clk) begin
        if (reset) begin
            wb_valid_ff <= 1'b0;
            wb_data_ff  <= 32'h0000_0000;
        end else begin
            wb_valid_ff <= accept & post_inc_on;
            if (accept & post_inc_on) begin
                wb_data_ff <= cmd_base + cmd_offset;
            end
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_ISSUE0;
                end
            end
            ST_ISSUE0: begin
                if (granted) begin
                    nxt_state = split_ff ? ST_ISSUE1 : ST_WAIT;
                end
            end
            ST_ISSUE1: begin
                if (granted) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (last_rsp) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Bus request phase
    // ****************************************
    // Request held until taken; attributes move only after a grant
    assign data_req       = (state_ff == ST_ISSUE0) | (state_ff == ST_ISSUE1);
    assign data_addr      = req_addr_ff;
    assign data_we        = we_ff;
    assign byte_lane_mask = req_mask_ff;
    assign data_wdata     = req_wd_ff;
    // No user, identifier, response-ready or error signals exist here

    // ****************************************
    // Response phase
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            outst_ff <= 2'h0;
        end else begin
            outst_ff <= outst_ff + {1'b0, granted} - {1'b0, data_rvalid};
        end
    end

    // Responses come back in issue order, so a count tells them apart
    always_ff @(posedge clk) begin
        if (reset) begin
            rsp_idx_ff <= 1'b0;
            word_lo_ff <= 32'h0000_0000;
        end else if (accept) begin
            rsp_idx_ff <= 1'b0;
        end else if (data_rvalid) begin
            rsp_idx_ff <= 1'b1;
            if (!rsp_idx_ff) begin
                word_lo_ff <= data_rdata;
            end
        end
    end

    assign merge_lo = split_ff ? word_lo_ff : data_rdata;

    lsbm_merge u_merge (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (last_rsp & ~we_ff),
        .word_lo   (merge_lo),
        .word_hi   (data_rdata),
        .ofs       (ofs_ff),
        .size      (size_ff),
        .sign_ext  (sign_ff),
        .out_valid (load_valid),
        .out_data  (load_data)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            store_done_ff <= 1'b0;
        end else begin
            store_done_ff <= last_rsp & we_ff;
        end
    end

    assign store_done    = store_done_ff;
    assign eff_addr      = eff_ff;
    assign base_wb_valid = wb_valid_ff;
    assign base_wb_data  = wb_data_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_accept;
        cmd_valid && cmd_ready;
    endsequence

    sequence s_first_split_grant;
        data_req && data_gnt && (state_ff == ST_ISSUE0) && split_ff;
    endsequence

    a_outst_limit: assert property (outst_ff <= OUTST_LIM)
        else $error("More than two transactions outstanding");

    a_req_held: assert property (data_req && !data_gnt |=> data_req)
        else $error("Request dropped before grant");

    a_phase_stable: assert property (data_req && !data_gnt |=>
        $stable(data_addr) && $stable(data_we) && $stable(byte_lane_mask)
        && $stable(data_wdata))
        else $error("Request attributes changed before grant");

    a_store_we: assert property (s_accept ##0 cmd_we |=> data_req && data_we)
        else $error("Store not issued with write select high");

    a_mask_set: assert property (data_req |-> byte_lane_mask != 4'h0)
        else $error("Request with empty lane mask");

    a_split_decide: assert property (s_accept ##0 (cmd_size == SIZE_WORD)
        ##0 (nxt_eff[1:0] != 2'h0) |=> split_ff)
        else $error("Misaligned word not split");

    a_low_first: assert property (s_first_split_grant |=>
        data_req && (data_addr == $past(data_addr) + WORD_STEP))
        else $error("Second half not at next word");

    a_single_txn: assert property (data_req && data_gnt && !split_ff
        |=> !data_req)
        else $error("Aligned access issued twice");

    a_post_inc: assert property (s_accept ##0 post_inc_on |=>
        base_wb_valid && (base_wb_data == $past(cmd_base) + $past(cmd_offset))
        && (eff_addr == $past(cmd_base)))
        else $error("Post-increment write-back wrong");

    a_load_result: assert property (last_rsp && !we_ff |=> load_valid)
        else $error("Load result missing after last response");

endmodule // lsbm_core

// *** dv/lsbm_mem_model.sv ***
// Behavioural data memory on the far side of the load-store bus master
module lsbm_mem_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        slow,
    input  wire logic        data_req,
    input  wire logic [31:0] data_addr,
    input  wire logic        data_we,
    input  wire logic [3:0]  byte_lane_mask,
    input  wire logic [31:0] data_wdata,
    output logic             data_gnt,
    output logic             data_rvalid,
    output logic      [31:0] data_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] mem [0:15];
    logic [31:0] q_data [$];
    int          q_due [$];
    int          cyc;

    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i / 4][8 * (i % 4) +: 8] = 8'(i * 37);
        end
        cyc         = 0;
        data_gnt    = 1'b0;
        data_rvalid = 1'b0;
        data_rdata  = 32'h0;
    end

    // ****************************************
    // Grant, write and ordered responses
    // ****************************************
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (reset) begin
            q_data.delete();
            q_due.delete();
            data_gnt    <= 1'b1;
            data_rvalid <= 1'b0;
        end else begin
            // Grant may stand before any request
            data_gnt <= slow ? !data_gnt : 1'b1;
            if (data_req && data_gnt) begin
                for (int j = 0; j < 4; j++) begin
                    if (data_we && byte_lane_mask[j]) begin
                        mem[data_addr[5:2]][8 * j +: 8] = data_wdata[8 * j +: 8];
                    end
                end
                // Write responses carry junk data
                q_data.push_back(data_we ? ~data_rdata : mem[data_addr[5:2]]);
                // Answer at least one cycle after the grant
                q_due.push_back(slow ? cyc + 2 : cyc);
            end
            // One pulse per grant, oldest first
            if (q_due.size() > 0 && q_due[0] <= cyc) begin
                data_rvalid <= 1'b1;
                data_rdata  <= q_data.pop_front();
                void'(q_due.pop_front());
            end else begin
                data_rvalid <= 1'b0;
                data_rdata  <= ~data_rdata;
            end
        end
    end
endmodule // lsbm_mem_model

// *** dv/lsbm_core_tb.sv ***
// Self-checking bench of the load-store bus master
module lsbm_core_tb
    import lsbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic        we;
        logic [1:0]  size;
        logic        sx;
        logic [31:0] a;
        logic [31:0] wd;
        logic [1:0]  n;
    } lsbm_row_s;

    logic        clk, reset, slow, cmd_valid, cmd_ready, cmd_we, cmd_sign_ext, cmd_post_inc;
    logic [1:0]  cmd_size;
    logic [31:0] cmd_base, cmd_offset, cmd_wdata, eff_addr, load_data, base_wb_data;
    logic        load_valid, store_done, base_wb_valid, data_req, data_gnt, data_we;
    logic        data_rvalid, t_we, p_pend, wb_seen, got_ld;
    logic [31:0] data_addr, data_wdata, data_rdata, wb_data, got;
    logic [3:0]  byte_lane_mask;
    logic [31:0] t_addr [2];
    logic [3:0]  t_mask [2];
    logic [68:0] p_ph;
    logic [7:0]  sh [64];
    int          n_errors, checked, n_txn, outst;

    lsbm_row_s rows [14] = '{
        '{1'b1, 2'h2, 1'b0, 32'h11, 32'hdeadbeef, 2'h2},
        '{1'b1, 2'h1, 1'b0, 32'h17, 32'h0000a55a, 2'h2},
        '{1'b1, 2'h0, 1'b0, 32'h1a, 32'h000000f0, 2'h1},
        '{1'b1, 2'h2, 1'b0, 32'h20, 32'h01234567, 2'h1},
        '{1'b1, 2'h1, 1'b0, 32'h26, 32'h0000817e, 2'h1},
        '{1'b0, 2'h2, 1'b0, 32'h11, 32'h0, 2'h2},
        '{1'b0, 2'h2, 1'b0, 32'h13, 32'h0, 2'h2},
        '{1'b0, 2'h2, 1'b0, 32'h22, 32'h0, 2'h2},
        '{1'b0, 2'h1, 1'b1, 32'h17, 32'h0, 2'h2},
        '{1'b0, 2'h1, 1'b0, 32'h15, 32'h0, 2'h1},
        '{1'b0, 2'h1, 1'b1, 32'h26, 32'h0, 2'h1},
        '{1'b0, 2'h0, 1'b1, 32'h1a, 32'h0, 2'h1},
        '{1'b0, 2'h0, 1'b0, 32'h1b, 32'h0, 2'h1},
        '{1'b0, 2'h2, 1'b0, 32'h20, 32'h0, 2'h1}
    };

    lsbm_core #(.vendor_extensions_enable(1'b1)) u_lsbm_core (.clk, .reset, .cmd_valid,
        .cmd_ready, .cmd_we, .cmd_size, .cmd_sign_ext, .cmd_post_inc, .cmd_base, .cmd_offset,
        .cmd_wdata, .eff_addr, .load_valid, .load_data, .store_done, .base_wb_valid,
        .base_wb_data, .data_req, .data_gnt, .data_addr, .data_we, .byte_lane_mask,
        .data_wdata, .data_rvalid, .data_rdata);

    lsbm_mem_model u_lsbm_mem_model (.clk, .reset, .slow, .data_req, .data_addr, .data_we,
        .byte_lane_mask, .data_wdata, .data_gnt, .data_rvalid, .data_rdata);

    // ****************************************
    // Reporting
    // ****************************************
    task automatic print_verdict();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            n_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    function automatic logic [31:0] exp_ld(input logic [31:0] a, input logic [1:0] sz,
                                           input logic sx);
        logic [31:0] v;
        int          nb;
        nb = 1 << sz;
        v  = 32'h0;
        for (int i = 0; i < nb; i++) v[8 * i +: 8] = sh[a[5:0] + 6'(i)];
        for (int i = nb; i < 4; i++) v[8 * i +: 8] = {8{sx & v[8 * nb - 1]}};
        return v;
    endfunction

    // ****************************************
    // Bus monitor
    // ****************************************
    always @(posedge clk) begin
        if (reset) begin
            outst  = 0;
            p_pend = 1'b0;
        end else begin
            if (p_pend) chk(data_req === 1'b1, "request dropped before grant");
            if (p_pend) chk({data_addr, data_we, byte_lane_mask, data_wdata} === p_ph,
                            "request phase changed before grant");
            if (data_req && data_gnt) begin
                if (n_txn < 2) t_addr[n_txn] = data_addr;
                if (n_txn < 2) t_mask[n_txn] = byte_lane_mask;
                if (n_txn == 0) t_we = data_we;
                n_txn++;
            end
            outst = outst + int'(data_req && data_gnt) - int'(data_rvalid);
            if (outst > 2) chk(1'b0, "more than two outstanding");
            p_pend = data_req && !data_gnt;
            p_ph   = {data_addr, data_we, byte_lane_mask, data_wdata};
        end
    end

    task automatic timeout();
        n_errors++;
        $display("ERROR %0t wait ran out", $time);
        print_verdict();
    endtask

    task automatic do_cmd(input logic we, input logic [1:0] sz, input logic sx,
                          input logic pi, input logic [31:0] b, o, wd);
        int k;
        @(negedge clk);
        {cmd_valid, cmd_we, cmd_size, cmd_sign_ext, cmd_post_inc} = {1'b1, we, sz, sx, pi};
        {cmd_base, cmd_offset, cmd_wdata} = {b, o, wd};
        n_txn = 0;
        k     = 0;
        while (cmd_ready !== 1'b1) begin
            k++;
            if (k > 50) timeout();
            @(negedge clk);
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        wb_seen   = base_wb_valid;
        wb_data   = base_wb_data;
        k         = 0;
        while (load_valid !== 1'b1 && store_done !== 1'b1) begin
            k++;
            if (k > 60) timeout();
            @(negedge clk);
        end
        got_ld = load_valid;
        got    = load_data;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        lsbm_row_s  r;
        logic [7:0] m8;
        {reset, slow, cmd_valid, cmd_we, cmd_size, cmd_sign_ext, cmd_post_inc} = 8'h80;
        {cmd_base, cmd_offset, cmd_wdata} = 96'h0;
        {n_errors, checked, n_txn} = '0;
        for (int a = 0; a < 64; a++) sh[a] = 8'(a * 37);
        repeat (5) @(negedge clk);
        reset = 1'b0;
        chk({cmd_ready, data_req, byte_lane_mask} === 6'h20, "reset");
        for (int p = 0; p < 2; p++) begin
            slow = p[0];
            foreach (rows[i]) begin
                r  = rows[i];
                m8 = ((8'h1 << (1 << r.size)) - 8'h1) << r.a[1:0];
                do_cmd(r.we, r.size, r.sx, 1'b0, r.a - 32'h4, 32'h4, r.wd);
                chk(eff_addr === r.a, "effective address");
                chk(n_txn == int'(r.n), "transaction count");
                chk(t_addr[0] === {r.a[31:2], 2'h0} && t_mask[0] === m8[3:0],
                    "first transfer");
                if (r.n == 2'h2) chk(t_addr[1] === t_addr[0] + 32'h4 && t_mask[1] === m8[7:4],
                                     "second transfer");
                chk(t_we === r.we, "write select");
                if (r.we) begin
                    chk(got_ld === 1'b0 && store_done === 1'b1, "store completion");
                    for (int b = 0; b < (1 << r.size); b++) begin
                        sh[r.a[5:0] + 6'(b)] = r.wd[8 * b +: 8];
                    end
                end else begin
                    chk(got === exp_ld(r.a, r.size, r.sx), "load data");
                end
            end
        end
        do_cmd(1'b0, SIZE_WORD, 1'b0, 1'b1, 32'h20, 32'h8, 32'h0);
        chk(eff_addr === 32'h20 && t_addr[0] === 32'h20, "post-increment address");
        chk(wb_seen === 1'b1 && wb_data === 32'h28, "post-increment write-back");
        do_cmd(1'b0, SIZE_WORD, 1'b0, 1'b0, 32'h20, 32'h8, 32'h0);
        chk(eff_addr === 32'h28 && wb_seen === 1'b0, "plain offset form");
        // Reset while a split load waits for its first grant, then the same load again
        @(negedge clk);
        {cmd_valid, cmd_we, cmd_size, cmd_post_inc} = {1'b1, 1'b0, SIZE_WORD, 1'b0};
        {cmd_base, cmd_offset} = {32'h11, 32'h0};
        @(negedge clk);
        cmd_valid = 1'b0;
        reset     = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        chk({cmd_ready, data_req, load_valid, store_done} === 4'h8, "mid-run reset");
        do_cmd(1'b0, SIZE_WORD, 1'b0, 1'b0, 32'h11, 32'h0, 32'h0);
        chk(n_txn == 2, "split after reset");
        chk(got === exp_ld(32'h11, SIZE_WORD, 1'b0), "load after reset");
        print_verdict();
    end
endmodule // lsbm_core_tb
